// ==== verilog/prsc_defines.vh ====
`ifndef PRSC_DEFINES_VH
`define PRSC_DEFINES_VH
// Register offsets on the byte-wide register port.
`define PRSC_ADDR_EXT_IRQ_FLAG  8'h91
`define PRSC_ADDR_POWER_MGMT    8'hC4
`define PRSC_ADDR_WATCHDOG_CTRL 8'hD8
`define PRSC_ADDR_IRQ_STATUS    8'hF0
`define PRSC_ADDR_IRQ_MASK      8'hF1
// Field positions.
`define PRSC_PMR_SEL_HI         7
`define PRSC_PMR_SEL_LO         6
`define PRSC_PMR_XTAL_OFF       3
`define PRSC_EXT_IRQ_FLAG_REG_XTAL_SEL      3
`define PRSC_EXT_IRQ_FLAG_REG_RING_ACTIVE   2
`define PRSC_WDC_POR_FLAG       6
`define PRSC_IRQ_POR            0
`define PRSC_IRQ_RATE           1
`define PRSC_IRQ_XTAL_UP        2
// Cycle-rate select codes.
`define PRSC_RATE_RSVD          2'h0
`define PRSC_RATE_DIV4          2'h1
`define PRSC_RATE_DIV64         2'h2
`define PRSC_RATE_DIV1024       2'h3
// Divider terminal counts, one less than the clocks per machine cycle.
`define PRSC_TERM_DIV4          10'h003
`define PRSC_TERM_DIV64         10'h03F
`define PRSC_TERM_DIV1024       10'h3FF
// Reset values and widths.
`define PRSC_CNT_ZERO           10'h000
`define PRSC_WARM_ZERO          17'h00000
`define PRSC_WARM_ONE           17'h00001
`define PRSC_BYTE_ZERO          8'h00
`define PRSC_IRQ_ZERO           3'h0
`define PRSC_RESET_VECTOR       16'h0000
`define PRSC_WARM_CYCLES        65536
`endif

// ==== verilog/prsc_power_reset.v ====
// Function
// - Hold CPU and all I/O in reset while supply is below threshold.
// - Drive active-low system reset output low while supply is below threshold.
// - After supply rises, enable crystal and count 65536 CPU clocks before release.
// - Then release system reset and core, program counter starting at 0000h.
// - On power-on reset set the power-on flag, bit 6 of watchdog control.
// - Power-on flag stays set until software clears it by a write.
// - By default each machine cycle takes 4 clocks of the selected source.
// - Slow clock mode runs the CPU at source divided by 64 or 1024.
// - Only a software write selects a reduced clock rate, never hardware.
// - In idle, peripherals keep running at the selected divisor, default four.
// - Software may switch to the ring oscillator, then turn off the crystal.
// - The ring oscillator source uses the same divisors 4, 64 and 1024.
// - Two-bit rate field: 00 reserved, 01 four, 10 sixty-four, 11 1024 clocks.
// - Read-only status bit shows 0 on crystal and 1 on ring oscillator.
//
// Implementation choices: the address map and strobed register access.
`include "prsc_defines.vh"
`default_nettype none
module prsc_power_reset #(
   parameter WARM_CYCLES = `PRSC_WARM_CYCLES
) (
   input  wire        i_clk,
   input  wire        i_rst_n,
   input  wire        i_supply_ok,
   input  wire        i_xtal_clk,
   input  wire        i_ring_clk,
   input  wire        i_idle,
   input  wire [7:0]  i_addr,
   input  wire [7:0]  i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [7:0]  o_rdata,
   output reg         o_supply_reset_out_n,
   output reg         o_core_rst_n,
   output wire [15:0] o_reset_vector,
   output reg         o_xtal_amp_en,
   output reg         o_cpu_cycle,
   output reg         o_periph_cycle,
   output wire        o_irq
);

   // The warm-up counters are seventeen bits wide, enough for the full warm-up length.
   localparam integer WARM_LAST = WARM_CYCLES - 1;
   localparam [16:0]  WARM_TERM = WARM_LAST[16:0];

   // Sequencer states, one-hot.
   localparam [2:0] ST_OFF  = 3'b001;
   localparam [2:0] ST_WARM = 3'b010;
   localparam [2:0] ST_RUN  = 3'b100;

   // Terminal count of the divider for a rate code; reserved acts as four.
   // The reserved code is never stored, so the fallback only guards an unreachable value.
   function [9:0] prsc_term;
      input [1:0] rate;
      begin
         if (rate == `PRSC_RATE_DIV64) begin
            prsc_term = `PRSC_TERM_DIV64;
         end else if (rate == `PRSC_RATE_DIV1024) begin
            prsc_term = `PRSC_TERM_DIV1024;
         end else begin
            prsc_term = `PRSC_TERM_DIV4;
         end
      end
   endfunction

   // Pin inputs pass three flops; a level counts once stages two and three agree.
   // A sample that disagrees with its neighbour may be metastable and is ignored.
   reg  [2:0] sync_s1;
   reg  [2:0] sync_s2;
   reg  [2:0] sync_s3;
   reg  [2:0] level;
   wire [2:0] pin_in = {i_ring_clk, i_xtal_clk, i_supply_ok};
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_sync
         always @(posedge i_clk) begin
            if (!i_rst_n) begin
               sync_s1[g] <= 1'b0;
               sync_s2[g] <= 1'b0;
               sync_s3[g] <= 1'b0;
               level[g]   <= 1'b0;
            end else begin
               sync_s1[g] <= pin_in[g];
               sync_s2[g] <= sync_s1[g];
               sync_s3[g] <= sync_s2[g];
               if (sync_s2[g] == sync_s3[g]) begin
                  level[g] <= sync_s3[g];
               end
            end
         end
      end
   endgenerate

   wire supply_ok = level[0];
   reg  xtal_lvl_d;
   reg  ring_lvl_d;
   wire xtal_tick = level[1] & ~xtal_lvl_d;
   wire ring_tick = level[2] & ~ring_lvl_d;

   // The supply monitor acts as a reset of its own on all control state.
   // Software therefore finds reset values in every register after a brownout.
   wire hold_rst = !i_rst_n || !supply_ok;

   reg  [2:0]  state;
   reg  [16:0] warm_cnt;
   reg  [9:0]  div_cnt;
   reg  [1:0]  rate_cur;
   reg  [1:0]  rate_req;
   reg         ring_cur;
   reg         xtal_sel;
   reg         xtal_off;
   reg         xtal_up;
   reg  [16:0] xwarm_cnt;
   reg         por_flag;
   reg  [2:0]  irq_status;
   reg  [2:0]  irq_mask;

   wire src_tick = ring_cur ? ring_tick : xtal_tick;
   wire boundary = src_tick && (div_cnt == prsc_term(rate_cur));

   // Edge history of the oscillator levels.
   // Both copies reset low like the levels they follow, so no false edge follows reset.
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         xtal_lvl_d <= 1'b0;
         ring_lvl_d <= 1'b0;
      end else begin
         xtal_lvl_d <= level[1];
         ring_lvl_d <= level[2];
      end
   end

   // Power-up sequencer: warm-up counts crystal clocks, which is the CPU clock in reset.
   // Release falls on an oscillator edge, so the first machine cycle is a whole one.
   always @(posedge i_clk) begin
      if (hold_rst) begin
         state                <= ST_OFF;
         warm_cnt             <= `PRSC_WARM_ZERO;
         o_supply_reset_out_n <= 1'b0;
         o_core_rst_n         <= 1'b0;
      end else begin
         case (state)
            ST_OFF: begin
               state <= ST_WARM;
            end
            ST_WARM: begin
               if (xtal_tick) begin
                  if (warm_cnt == WARM_TERM) begin
                     state                <= ST_RUN;
                     o_supply_reset_out_n <= 1'b1;
                     o_core_rst_n         <= 1'b1;
                  end else begin
                     warm_cnt <= warm_cnt + `PRSC_WARM_ONE;
                  end
               end
            end
            ST_RUN: begin
               state <= ST_RUN;
            end
            default: begin
               state <= ST_OFF;
            end
         endcase
      end
   end

   assign o_reset_vector = `PRSC_RESET_VECTOR;

   wire running  = (state == ST_RUN);
   wire release_ev = (state == ST_WARM) && xtal_tick && (warm_cnt == WARM_TERM);

   // Register write decode.
   wire wr_pmr  = i_wr && (i_addr == `PRSC_ADDR_POWER_MGMT);
   wire wr_ext_irq_flag_reg = i_wr && (i_addr == `PRSC_ADDR_EXT_IRQ_FLAG);
   wire wr_wdc  = i_wr && (i_addr == `PRSC_ADDR_WATCHDOG_CTRL);
   wire wr_ist  = i_wr && (i_addr == `PRSC_ADDR_IRQ_STATUS);
   wire wr_imk  = i_wr && (i_addr == `PRSC_ADDR_IRQ_MASK);
   wire [1:0] wr_rate = {i_wdata[`PRSC_PMR_SEL_HI], i_wdata[`PRSC_PMR_SEL_LO]};

   // Slow rates may only be entered from the four-clock rate; the reserved code is dropped.
   // Software must step back to four clocks before choosing the other slow rate.
   wire rate_ok = (wr_rate != `PRSC_RATE_RSVD) &&
                  ((wr_rate == `PRSC_RATE_DIV4) || (rate_cur == `PRSC_RATE_DIV4));

   // Rate select: only a software write changes the request.
   // A refused write leaves the old request in place and gives no indication.
   always @(posedge i_clk) begin
      if (hold_rst) begin
         rate_req <= `PRSC_RATE_DIV4;
      end else if (wr_pmr && rate_ok) begin
         rate_req <= wr_rate;
      end
   end

   // Crystal amplifier control; turning it off needs the ring selected.
   // Stopping the amplifier while it still clocks the core would freeze the divider.
   always @(posedge i_clk) begin
      if (hold_rst) begin
         xtal_off <= 1'b0;
      end else if (wr_pmr) begin
         if (!i_wdata[`PRSC_PMR_XTAL_OFF]) begin
            xtal_off <= 1'b0;
         end else if (!xtal_sel && ring_cur) begin
            xtal_off <= 1'b1;
         end
      end
   end

   always @(posedge i_clk) begin
      if (hold_rst) begin
         o_xtal_amp_en <= 1'b1;
      end else begin
         o_xtal_amp_en <= !xtal_off;
      end
   end

   // Crystal warm-up after a restart; the crystal is known good once the core runs.
   // The count starts again from zero each time the amplifier is stopped.
   always @(posedge i_clk) begin
      if (hold_rst) begin
         xtal_up   <= 1'b0;
         xwarm_cnt <= `PRSC_WARM_ZERO;
      end else if (xtal_off) begin
         xtal_up   <= 1'b0;
         xwarm_cnt <= `PRSC_WARM_ZERO;
      end else if (release_ev) begin
         xtal_up <= 1'b1;
      end else if (running && !xtal_up && xtal_tick) begin
         if (xwarm_cnt == WARM_TERM) begin
            xtal_up <= 1'b1;
         end else begin
            xwarm_cnt <= xwarm_cnt + `PRSC_WARM_ONE;
         end
      end
   end

   // Source select; a return to the crystal is refused until it has warmed up.
   // Without this guard the core could be moved onto a crystal that has not settled.
   always @(posedge i_clk) begin
      if (hold_rst) begin
         xtal_sel <= 1'b1;
      end else if (wr_ext_irq_flag_reg) begin
         if (!i_wdata[`PRSC_EXT_IRQ_FLAG_REG_XTAL_SEL]) begin
            xtal_sel <= 1'b0;
         end else if (xtal_up) begin
            xtal_sel <= 1'b1;
         end
      end
   end

   // Divider: rate and source are swapped only on the last clock of a machine cycle,
   // so the CPU never sees a short cycle while the selection changes.
   // Idle gates only the core pulse; peripherals keep their cadence.
   always @(posedge i_clk) begin
      if (hold_rst) begin
         div_cnt        <= `PRSC_CNT_ZERO;
         rate_cur       <= `PRSC_RATE_DIV4;
         ring_cur       <= 1'b0;
         o_cpu_cycle    <= 1'b0;
         o_periph_cycle <= 1'b0;
      end else begin
         o_cpu_cycle    <= boundary && running && !i_idle;
         o_periph_cycle <= boundary && running;
         if (boundary) begin
            div_cnt  <= `PRSC_CNT_ZERO;
            rate_cur <= rate_req;
            ring_cur <= !xtal_sel;
         end else if (src_tick) begin
            div_cnt <= div_cnt + 10'h001;
         end
      end
   end

   // The rate event marks the boundary at which a new rate is applied, not the write.
   wire rate_ev = boundary && (rate_cur != rate_req);

   // Power-on flag: set at release, cleared by writing its bit to zero.
   // Writing a one leaves the flag alone, so rewriting other bits cannot lose it.
   always @(posedge i_clk) begin
      if (hold_rst) begin
         por_flag <= 1'b0;
      end else if (release_ev) begin
         por_flag <= 1'b1;
      end else if (wr_wdc && !i_wdata[`PRSC_WDC_POR_FLAG]) begin
         por_flag <= 1'b0;
      end
   end

   // Sticky interrupt status; an event in the clearing cycle wins over the clear.
   // Status and mask share one layout, so the interrupt is a plain masked OR.
   wire [2:0] irq_set;
   assign irq_set[`PRSC_IRQ_POR]     = release_ev;
   assign irq_set[`PRSC_IRQ_RATE]    = rate_ev;
   assign irq_set[`PRSC_IRQ_XTAL_UP] = running && !xtal_up && xtal_tick &&
                                       !xtal_off && (xwarm_cnt == WARM_TERM);
   wire [2:0] irq_clr = wr_ist ? i_wdata[2:0] : `PRSC_IRQ_ZERO;

   always @(posedge i_clk) begin
      if (hold_rst) begin
         irq_status <= `PRSC_IRQ_ZERO;
         irq_mask   <= `PRSC_IRQ_ZERO;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
         if (wr_imk) begin
            irq_mask <= i_wdata[2:0];
         end
      end
   end

   assign o_irq = |(irq_status & irq_mask);

   // Read mux; reserved bits and unmapped addresses read zero.
   // Reads have no side effects, so a stray read cannot lose an event.
   reg [7:0] rd_val;
   always @* begin
      rd_val = `PRSC_BYTE_ZERO;
      if (i_addr == `PRSC_ADDR_POWER_MGMT) begin
         rd_val[`PRSC_PMR_SEL_HI]   = rate_req[1];
         rd_val[`PRSC_PMR_SEL_LO]   = rate_req[0];
         rd_val[`PRSC_PMR_XTAL_OFF] = xtal_off;
      end else if (i_addr == `PRSC_ADDR_EXT_IRQ_FLAG) begin
         rd_val[`PRSC_EXT_IRQ_FLAG_REG_XTAL_SEL]   = xtal_sel;
         rd_val[`PRSC_EXT_IRQ_FLAG_REG_RING_ACTIVE] = ring_cur;
      end else if (i_addr == `PRSC_ADDR_WATCHDOG_CTRL) begin
         rd_val[`PRSC_WDC_POR_FLAG] = por_flag;
      end else if (i_addr == `PRSC_ADDR_IRQ_STATUS) begin
         rd_val[2:0] = irq_status;
      end else if (i_addr == `PRSC_ADDR_IRQ_MASK) begin
         rd_val[2:0] = irq_mask;
      end
   end

   // Read data stands for one cycle after the strobe and is zero otherwise.
   // Returning zero between reads keeps an OR of several read buses simple.
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rdata <= `PRSC_BYTE_ZERO;
      end else if (i_rd) begin
         o_rdata <= rd_val;
      end else begin
         o_rdata <= `PRSC_BYTE_ZERO;
      end
   end

endmodule
`default_nettype wire

// ==== tb/prsc_osc_model.sv ====
`default_nettype none
// Crystal and ring oscillators that feed the block, as slow square waves.
module prsc_osc_model (
   input  wire logic i_amp_en,
   output var  logic o_xtal_clk,
   output var  logic o_ring_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   // The crystal stands still while its amplifier is off, as a real one would.
   initial begin
      o_xtal_clk = 1'b0;
      #2;
      forever #20 if (i_amp_en === 1'b1) o_xtal_clk = ~o_xtal_clk;
   end
   // The ring runs free; its edges never meet a clock edge.
   initial begin
      o_ring_clk = 1'b0;
      #1;
      forever #15 o_ring_clk = ~o_ring_clk;
   end
endmodule
`default_nettype wire

// ==== tb/prsc_power_reset_sva.sv ====
`default_nettype none
// Port checks on reset, interrupt and machine-cycle outputs.
module prsc_power_reset_sva #(
   parameter WARM_CYCLES = 65536
) (
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic        i_supply_ok,
   input wire logic        i_idle,
   input wire logic        i_rd,
   input wire logic [7:0]  o_rdata,
   input wire logic        o_supply_reset_out_n,
   input wire logic        o_core_rst_n,
   input wire logic [15:0] o_reset_vector,
   input wire logic        o_xtal_amp_en,
   input wire logic        o_cpu_cycle,
   input wire logic        o_periph_cycle,
   input wire logic        o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // Reset itself must be watched, so this one is never disabled.
   rst_hold_a: assert property (disable iff (1'b0) !i_rst_n |=> !o_supply_reset_out_n && !o_core_rst_n)
      else $error("reset outputs high during reset");
   supply_low_a: assert property (!i_supply_ok [*8] |=> ##1 !o_supply_reset_out_n)
      else $error("reset output high with supply low");
   core_pair_a: assert property (o_core_rst_n == o_supply_reset_out_n)
      else $error("core and system reset differ");
   reset_vector_a: assert property (o_reset_vector == 16'h0000)
      else $error("reset vector not zero");
   amp_on_a: assert property (!o_core_rst_n |-> o_xtal_amp_en)
      else $error("crystal off during reset");
   idle_gate_a: assert property (i_idle && $past(i_idle) |-> !o_cpu_cycle)
      else $error("cpu pulse during idle");
   pulse_pair_a: assert property (o_cpu_cycle |-> o_periph_cycle)
      else $error("cpu pulse without peripheral pulse");
   pulse_single_a: assert property (o_periph_cycle |=> !o_periph_cycle)
      else $error("machine-cycle pulse too long");
   hold_quiet_a: assert property (!o_core_rst_n |-> !o_periph_cycle && !o_irq)
      else $error("activity during reset hold");
   rdata_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data without a read");
endmodule
bind prsc_power_reset prsc_power_reset_sva #(.WARM_CYCLES(WARM_CYCLES)) u_sva (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_supply_ok(i_supply_ok), .i_idle(i_idle), .i_rd(i_rd),
   .o_rdata(o_rdata), .o_supply_reset_out_n(o_supply_reset_out_n), .o_core_rst_n(o_core_rst_n),
   .o_reset_vector(o_reset_vector), .o_xtal_amp_en(o_xtal_amp_en), .o_cpu_cycle(o_cpu_cycle),
   .o_periph_cycle(o_periph_cycle), .o_irq(o_irq));
`default_nettype wire

// ==== tb/prsc_power_reset_tb_top.sv ====
`default_nettype none
module prsc_power_reset_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WARM = 8;
   logic        clk, rst_n, sup, idle, wr, rd, xclk, rclk;
   logic        sro_n, core_n, amp, cpu, pcyc, irq;
   logic [7:0]  addr, wdata, rdata, d;
   logic [15:0] vec;
   int          mismatches, comparisons, n;
   // Short warm-up keeps the run brief; expectations use WARM.
   prsc_power_reset #(.WARM_CYCLES(WARM)) u_dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_supply_ok(sup), .i_xtal_clk(xclk), .i_ring_clk(rclk),
      .i_idle(idle), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .o_supply_reset_out_n(sro_n), .o_core_rst_n(core_n), .o_reset_vector(vec),
      .o_xtal_amp_en(amp), .o_cpu_cycle(cpu), .o_periph_cycle(pcyc), .o_irq(irq));
   prsc_osc_model u_osc (.i_amp_en(amp), .o_xtal_clk(xclk), .o_ring_clk(rclk));
   // Clock at 200 MHz.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // Cycles up to the next machine-cycle pulse, bounded.
   task automatic gap;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (pcyc !== 1'b1 && n < 20000);
   endtask
   task automatic measure(input int exp);
      gap();
      gap();
      chk(n, exp);
   endtask
   task automatic t_power_up;
      repeat (10) @(posedge clk);
      #1;
      chk(sro_n, 0);
      chk(core_n, 0);
      @(posedge clk);
      sup <= 1'b1;
      n = 0;
      while (sro_n !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(n >= 8 * WARM, 1);
      chk(core_n, 1);
      chk(vec, 16'h0000);
      rd_reg(8'hD8);
      chk(d[6], 1);
      rd_reg(8'h91);
      chk(d[3:2], 2'h2);
   endtask
   task automatic t_flag_irq;
      wr_reg(8'hD8, 8'hFF);
      rd_reg(8'hD8);
      chk(d[6], 1);
      wr_reg(8'hD8, 8'h00);
      rd_reg(8'hD8);
      chk(d[6], 0);
      chk(irq, 0);
      wr_reg(8'hF1, 8'h01);
      chk(irq, 1);
      wr_reg(8'hF0, 8'h01);
      chk(irq, 0);
      wr_reg(8'hF1, 8'h02);
   endtask
   // Crystal period is 8 clocks, so one machine cycle is 8 times the divisor.
   task automatic t_rates;
      measure(32);
      wr_reg(8'hC4, 8'h00);
      rd_reg(8'hC4);
      chk(d[7:6], 2'h1);
      chk(irq, 0);
      wr_reg(8'hC4, 8'h80);
      measure(512);
      chk(irq, 1);
      wr_reg(8'hF0, 8'h02);
      chk(irq, 0);
      wr_reg(8'hC4, 8'hC0);
      rd_reg(8'hC4);
      chk(d[7:6], 2'h2);
      wr_reg(8'hC4, 8'h40);
      measure(32);
   endtask
   task automatic t_idle;
      int c;
      int p;
      c = 0;
      p = 0;
      @(posedge clk);
      idle <= 1'b1;
      repeat (2) @(posedge clk);
      repeat (200) begin
         @(posedge clk);
         #1;
         if (cpu === 1'b1) c++;
         if (pcyc === 1'b1) p++;
      end
      chk(c, 0);
      chk(p >= 6, 1);
      @(posedge clk);
      idle <= 1'b0;
      c = 0;
      repeat (100) begin
         @(posedge clk);
         #1;
         if (cpu === 1'b1) c++;
      end
      chk(c >= 3, 1);
   endtask
   // Ring period is 6 clocks.
   task automatic t_ring;
      wr_reg(8'h91, 8'h00);
      repeat (100) @(posedge clk);
      rd_reg(8'h91);
      chk(d[2], 1);
      wr_reg(8'hC4, 8'h48);
      repeat (4) @(posedge clk);
      #1;
      chk(amp, 0);
      measure(24);
      wr_reg(8'hC4, 8'hC8);
      measure(6144);
      rd_reg(8'h00);
      chk(d, 8'h00);
   endtask
   // Back to the crystal: restart it, wait until it has settled, then select it.
   task automatic t_xtal_back;
      wr_reg(8'hC4, 8'h40);
      wr_reg(8'h91, 8'h08);
      rd_reg(8'h91);
      chk(d[3:2], 2'h1);
      repeat (100) @(posedge clk);
      rd_reg(8'hF0);
      chk(d[2], 1);
      chk(amp, 1);
      wr_reg(8'h91, 8'h08);
      rd_reg(8'h91);
      chk(d[3:2], 2'h3);
      repeat (6300) @(posedge clk);
      rd_reg(8'h91);
      chk(d[3:2], 2'h2);
      measure(32);
   endtask
   // Supply loss, then a second power-up after the flag was cleared earlier.
   task automatic t_supply_drop;
      @(posedge clk);
      sup <= 1'b0;
      repeat (12) @(posedge clk);
      #1;
      chk(sro_n, 0);
      chk(core_n, 0);
      chk(amp, 1);
      @(posedge clk);
      sup <= 1'b1;
      n = 0;
      while (sro_n !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(core_n, 1);
      rd_reg(8'hD8);
      chk(d[6], 1);
      rd_reg(8'h91);
      chk(d[3:2], 2'h2);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Main sequence, with supply low through the reset.
   initial begin
      mismatches = 0;
      comparisons = 0;
      rst_n = 1'b0;
      sup = 1'b0;
      idle = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_power_up();
      t_flag_irq();
      t_rates();
      t_idle();
      t_ring();
      t_xtal_back();
      t_supply_drop();
      final_report();
   end
   // The whole run needs about 75 us; a hang is cut short well after.
   initial begin
      #400us;
      mismatches++;
      final_report();
   end
endmodule
`default_nettype wire
